/* apo_top.sv */
// digital output side of an 8-bit pipelined converter
// Behaviour
// - sample on rising true sampling clock edge
// - output word appears nine sample cycles later
// - word and flag valid at next data-clock rise
// - drive differential data clock from sampling clock
// - divide select low halves output update rate
// - divide select high updates every input cycle
// - divide select defaults low when unconnected
// - format low two's complement, high offset binary
// - format select defaults low when unconnected
// - out of range beyond either full scale
// - true flag high, complement low when out
// - clamp codes at full scale, midscale 1000 0000 offset binary, 0000 0000 two's complement
// - correction merges stage results into one word
`timescale 1ns/10ps
module apo_top (
    // clock, reset, enable
    input wire logic clock,
    input wire logic reset_n,
    input wire logic clk_en,
    // sampling clock pins
    input wire logic sample_clk_true,
    input wire logic sample_clk_comp,
    // digitised analog input pair
    input wire logic [9:0] analog_in_pos,
    input wire logic [9:0] analog_in_neg,
    // control pins
    input wire logic clock_divide_select,
    input wire logic format_select,
    // parallel word pairs
    output logic [7:0] sample_word_true,
    output logic [7:0] sample_word_comp,
    // range flag pair
    output logic range_flag_true,
    output logic range_flag_comp,
    // data clock pair
    output logic data_clk_out_true,
    output logic data_clk_out_comp
);
    // all registered state of the top except the assertion helpers
    typedef struct packed {
        logic [2:0] sclk_t;             // true sampling clock synchroniser plus edge tap
        logic [1:0] sclk_c;             // complement sampling clock synchroniser
        logic [1:0] div_sel;            // divide select synchroniser
        logic [1:0] fmt_sel;            // format select synchroniser
        logic [9:0] pos_s1;             // analog positive, first stage
        logic [9:0] pos_s2;             // analog positive, second stage
        logic [9:0] neg_s1;             // analog negative, first stage
        logic [9:0] neg_s2;             // analog negative, second stage
        logic phase;                    // divider phase
        logic [7:0] cap_res;            // captured clamped code
        logic cap_over;                 // captured range flag
        logic [7:0] word;               // true word output
        logic [7:0] word_n;             // complement word output
        logic over;                     // true range flag output
        logic over_n;                   // complement range flag output
        apo_pkg::apo_dck_e dck;         // data clock phase
    } apo_top_s;

    apo_top_s st_q;
    apo_top_s st_d;

    // combinational helpers
    logic sample_edge;                  // rising true sampling clock seen
    logic tick;                         // effective sample, pipeline advances
    logic signed [11:0] diff;           // differential input code
    logic signed [11:0] biased;         // difference shifted to start at zero
    logic over_now;                     // current input beyond full scale
    logic [7:0] clamp_now;              // current clamped offset binary code
    logic [7:0] coded;                  // coder output
    logic [7:0] exp_word;               // expected word, assertion helper

    // stage chain carriers
    apo_stage_if chain [apo_pkg::APO_STAGES+1] ();

    // the capture register feeds the chain
    assign chain[0].res = st_q.cap_res;
    assign chain[0].code = apo_pkg::APO_WORD_RST;
    assign chain[0].over = st_q.cap_over;

    // one stage per resolved bit, most significant first
    for (genvar gi = 0; gi < apo_pkg::APO_STAGES; gi++) begin : g_stage
        apo_stage #(
            .BIT(apo_pkg::APO_STAGES - 1 - gi)
        ) u_stage (
            .clock(clock),
            .reset_n(reset_n),
            .tick(tick),
            .prev(chain[gi]),
            .next(chain[gi+1])
        );
    end

    // output coding
    apo_coder u_coder (
        .word_in(chain[apo_pkg::APO_STAGES]),
        .offset_binary(st_q.fmt_sel[1]),
        .word_out(coded)
    );

    // edge detect, divider and input quantising
    always_comb begin
        // rising edge of the synchronised true sampling clock
        sample_edge = clk_en && st_q.sclk_t[1] && !st_q.sclk_t[2];
        // bypass: every edge; divide: every other edge
        if (st_q.div_sel[1]) begin
            tick = sample_edge;
        end else begin
            tick = sample_edge && !st_q.phase;
        end
        diff = $signed({2'b00, st_q.pos_s2}) - $signed({2'b00, st_q.neg_s2});
        biased = diff + apo_pkg::APO_FULL_SCALE;
        // beyond either full scale
        over_now = (diff > apo_pkg::APO_FULL_SCALE) || (diff < -apo_pkg::APO_FULL_SCALE);
        // clamp at both ends, midscale lands on 1000 0000
        if (diff >= apo_pkg::APO_FULL_SCALE) begin
            clamp_now = apo_pkg::APO_CODE_MAX;
        end else if (diff <= -apo_pkg::APO_FULL_SCALE) begin
            clamp_now = apo_pkg::APO_CODE_MIN;
        end else begin
            clamp_now = biased[8:1];
        end
    end

    // next state
    always_comb begin
        st_d = st_q;
        if (clk_en) begin
            // pin synchronisers, the first flop feeds only the second
            st_d.sclk_t = {st_q.sclk_t[1:0], sample_clk_true};
            st_d.sclk_c = {st_q.sclk_c[0], sample_clk_comp};
            st_d.div_sel = {st_q.div_sel[0], clock_divide_select};
            st_d.fmt_sel = {st_q.fmt_sel[0], format_select};
            st_d.pos_s1 = analog_in_pos;
            st_d.pos_s2 = st_q.pos_s1;
            st_d.neg_s1 = analog_in_neg;
            st_d.neg_s2 = st_q.neg_s1;
            // divider phase turns on every edge
            if (sample_edge) begin
                st_d.phase = !st_q.phase;
            end
            // data clock rises one cycle after new data is out
            if (tick) begin
                st_d.dck = apo_pkg::APO_DCK_LOW;
            end else begin
                st_d.dck = apo_pkg::APO_DCK_HIGH;
            end
            if (tick) begin
                // capture the sample and advance the output
                st_d.cap_res = clamp_now;
                st_d.cap_over = over_now;
                st_d.word = coded;
                st_d.word_n = ~coded;
                st_d.over = chain[apo_pkg::APO_STAGES].over;
                st_d.over_n = ~chain[apo_pkg::APO_STAGES].over;
            end
        end
    end

    // state register; selects reset low, as an open pin would read
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= '0;
            st_q.div_sel <= {2{apo_pkg::APO_SEL_RST}};
            st_q.fmt_sel <= {2{apo_pkg::APO_SEL_RST}};
            st_q.word_n <= ~apo_pkg::APO_WORD_RST;
            st_q.over_n <= 1'b1;
            st_q.dck <= apo_pkg::APO_DCK_LOW;
        end else begin
            st_q <= st_d;
        end
    end

    // outputs straight from flops
    assign sample_word_true = st_q.word;
    assign sample_word_comp = st_q.word_n;
    assign range_flag_true = st_q.over;
    assign range_flag_comp = st_q.over_n;
    assign data_clk_out_true = st_q.dck[1];
    assign data_clk_out_comp = st_q.dck[0];

    // assertion helpers: shadow of captured samples, edge count between ticks
    logic [7:0] sh_code [apo_pkg::APO_LATENCY];
    logic sh_over [apo_pkg::APO_LATENCY];
    logic [1:0] edges_since;
    logic held_low;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < apo_pkg::APO_LATENCY; i++) begin
                sh_code[i] <= '0;
                sh_over[i] <= 1'b0;
            end
            edges_since <= 2'h1;
            held_low <= 1'b0;
        end else if (clk_en) begin
            if (tick) begin
                sh_code[0] <= clamp_now;
                sh_over[0] <= over_now;
                for (int i = 1; i < apo_pkg::APO_LATENCY; i++) begin
                    sh_code[i] <= sh_code[i-1];
                    sh_over[i] <= sh_over[i-1];
                end
                edges_since <= 2'h0;
                held_low <= !st_q.div_sel[1];
            end else begin
                if (sample_edge && edges_since != 2'h3) begin
                    edges_since <= edges_since + 2'h1;
                end
                if (st_q.div_sel[1]) begin
                    held_low <= 1'b0;
                end
            end
        end
    end

    assign exp_word = st_q.fmt_sel[1] ? sh_code[apo_pkg::APO_LATENCY-1]
                                      : sh_code[apo_pkg::APO_LATENCY-1] ^ apo_pkg::APO_SIGN_FLIP;

    // named steps of an output update
    sequence s_update;
        tick;
    endsequence
    sequence s_dck_rise;
        !data_clk_out_true ##1 (data_clk_out_true || !$past(clk_en));
    endsequence

    edge_is_rise_a: assert property (@(posedge clock) disable iff (!reset_n)
        tick |-> (st_q.sclk_t[1] && !st_q.sclk_t[2]))
        else $error("sample taken off a rising edge");
    latency_nine_a: assert property (@(posedge clock) disable iff (!reset_n)
        s_update |=> (sample_word_true == $past(exp_word)))
        else $error("word does not match sample nine ticks back");
    flag_aligned_a: assert property (@(posedge clock) disable iff (!reset_n)
        s_update |=> (range_flag_true == $past(sh_over[apo_pkg::APO_LATENCY-1])))
        else $error("range flag not aligned with its word");
    dck_after_data_a: assert property (@(posedge clock) disable iff (!reset_n)
        s_update |=> s_dck_rise)
        else $error("data clock did not rise after update");
    dck_pair_a: assert property (@(posedge clock) disable iff (!reset_n)
        data_clk_out_true != data_clk_out_comp)
        else $error("data clock pair not complementary");
    half_rate_a: assert property (@(posedge clock) disable iff (!reset_n)
        (tick && held_low && !st_q.div_sel[1]) |-> (edges_since == 2'h1))
        else $error("divided rate did not skip exactly one edge");
    bypass_rate_a: assert property (@(posedge clock) disable iff (!reset_n)
        (sample_edge && st_q.div_sel[1]) |-> tick)
        else $error("bypass mode skipped an edge");
    range_pair_a: assert property (@(posedge clock) disable iff (!reset_n)
        (range_flag_true != range_flag_comp) && (sample_word_true == ~sample_word_comp))
        else $error("output pair not complementary");
    clamp_top_a: assert property (@(posedge clock) disable iff (!reset_n)
        (tick && diff >= apo_pkg::APO_FULL_SCALE) |=> (st_q.cap_res == apo_pkg::APO_CODE_MAX))
        else $error("positive full scale not clamped");
    range_detect_a: assert property (@(posedge clock) disable iff (!reset_n)
        tick |=> (st_q.cap_over == $past((diff > apo_pkg::APO_FULL_SCALE)
                                         || (diff < -apo_pkg::APO_FULL_SCALE))))
        else $error("range flag wrong at capture");

    // guards on the lower clamp, midscale, holding, freeze, divider and data clock idle
    // negative full scale and below land on the bottom code
    clamp_bottom_a: assert property (@(posedge clock) disable iff (!reset_n)
        (tick && diff <= -apo_pkg::APO_FULL_SCALE) |=> (st_q.cap_res == apo_pkg::APO_CODE_MIN))
        else $error("negative full scale not clamped");

    // a zero difference lands on the midscale code, the sign bit alone
    clamp_mid_a: assert property (@(posedge clock) disable iff (!reset_n)
        (tick && diff == 12'sh000) |=> (st_q.cap_res == apo_pkg::APO_SIGN_FLIP))
        else $error("midscale code wrong");

    // a sample flagged out of range is captured at one of the end codes
    range_clamped_a: assert property (@(posedge clock) disable iff (!reset_n)
        (tick && over_now) |=> (st_q.cap_over && (st_q.cap_res == apo_pkg::APO_CODE_MAX
                                                  || st_q.cap_res == apo_pkg::APO_CODE_MIN)))
        else $error("out of range sample not at an end code");

    // word and flag stand until the next update
    words_stand_a: assert property (@(posedge clock) disable iff (!reset_n)
        !tick |=> ($stable(sample_word_true) && $stable(range_flag_true)))
        else $error("output changed without an update");

    // enable low holds every flop of the top
    freeze_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
        !clk_en |=> $stable(st_q))
        else $error("state moved while enable was low");

    // two updates never fall in neighbouring cycles
    tick_gap_a: assert property (@(posedge clock) disable iff (!reset_n)
        tick |=> !tick)
        else $error("updates in neighbouring cycles");

    // divided mode ignores an edge that arrives on the odd phase
    divide_skip_a: assert property (@(posedge clock) disable iff (!reset_n)
        (sample_edge && !st_q.div_sel[1] && st_q.phase) |-> !tick)
        else $error("divided rate took an odd edge");

    // the data clock only falls on the same edge that loads an update
    dck_idle_high_a: assert property (@(posedge clock) disable iff (!reset_n)
        (data_clk_out_true && clk_en && !tick) |=> data_clk_out_true)
        else $error("data clock fell without an update");
endmodule

/* apo_pkg.sv */
// constants shared by the pipelined converter output block
package apo_pkg;
    // output word and digitised analog input widths
    localparam int APO_WORD_W = 8;
    localparam int APO_AIN_W = 10;
    // samples between capture and output word
    localparam int APO_LATENCY = 9;
    // one capture register, then one register per resolved bit, then the output register
    localparam int APO_STAGES = APO_LATENCY - 1;
    // differential code that stands for positive full scale
    localparam logic signed [11:0] APO_FULL_SCALE = 12'sh100;
    // word codes
    localparam logic [7:0] APO_CODE_MAX = 8'hff;
    localparam logic [7:0] APO_CODE_MIN = 8'h00;
    localparam logic [7:0] APO_SIGN_FLIP = 8'h80;
    // reset values
    localparam logic [7:0] APO_WORD_RST = 8'h00;
    localparam logic APO_SEL_RST = 1'b0;
    // system clock period
    localparam int APO_CLK_PERIOD_NS = 100;
    // data clock phase, one-hot: bit 1 drives the true output, bit 0 the complement
    typedef enum logic [1:0] {
        APO_DCK_LOW = 2'b01,
        APO_DCK_HIGH = 2'b10
    } apo_dck_e;
endpackage

/* apo_stage_if.sv */
// carrier between pipeline stages: residue, partial code and range flag
`timescale 1ns/10ps
interface apo_stage_if;
    logic [7:0] res;   // part of the sample not yet resolved
    logic [7:0] code;  // bits resolved so far
    logic over;        // out-of-range flag of the same sample
    modport src (output res, output code, output over);
    modport snk (input res, input code, input over);
endinterface

/* apo_stage.sv */
// one pipeline stage: resolves one bit of the word and passes the residue on
`timescale 1ns/10ps
module apo_stage #(
    parameter int BIT = 7
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // advance strobe, one per effective sample
    input wire logic tick,
    // previous and next stage
    apo_stage_if.snk prev,
    apo_stage_if.src next
);
    localparam logic [7:0] WEIGHT = 8'(1 << BIT);

    // stage state
    typedef struct packed {
        logic [7:0] res;
        logic [7:0] code;
        logic over;
    } apo_stage_s;

    apo_stage_s st_q;
    apo_stage_s st_d;

    // compare the residue with this bit's weight and merge the bit into the code
    always_comb begin
        st_d = st_q;
        if (tick) begin
            st_d.over = prev.over;
            st_d.code = prev.code;
            if (prev.res >= WEIGHT) begin
                st_d.code[BIT] = 1'b1;
                st_d.res = prev.res - WEIGHT;
            end else begin
                st_d.code[BIT] = 1'b0;
                st_d.res = prev.res;
            end
        end
    end

    // register the stage
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign next.res = st_q.res;
    assign next.code = st_q.code;
    assign next.over = st_q.over;

    // after a step the residue is below this bit's weight
    resid_bound_a: assert property (@(posedge clock) disable iff (!reset_n)
        tick |=> (st_q.res < WEIGHT))
        else $error("stage residue not below bit weight");
endmodule

/* apo_coder.sv */
// output coder: chooses offset binary or two's complement
`timescale 1ns/10ps
module apo_coder (
    // last stage output
    apo_stage_if.snk word_in,
    // format select, high for offset binary
    input wire logic offset_binary,
    // coded word
    output logic [7:0] word_out
);
    // flip the sign bit for two's complement
    always_comb begin
        if (offset_binary) begin
            word_out = word_in.code;
        end else begin
            word_out = word_in.code ^ apo_pkg::APO_SIGN_FLIP;
        end
    end
endmodule

/* apo_rx_model.sv */
// receiving latch model: captures word and range flag on each data clock rise
`timescale 1ns/10ps
module apo_rx_model (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // lines from the converter
    input wire logic [7:0] word,
    input wire logic flag,
    input wire logic dck,
    // latched sample and running sample count
    output logic [7:0] rx_word,
    output logic rx_flag,
    output logic [7:0] rx_count
);
    // data clock level seen at the previous edge, for rise detection
    logic dck_q;
    // one latch per rise; the count wraps, so only differences are used
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            dck_q <= 1'b0;
            rx_word <= 8'h00;
            rx_flag <= 1'b0;
            rx_count <= 8'h00;
        end else begin
            dck_q <= dck;
            // word and flag are taken together as one sample
            if (dck && !dck_q) begin
                rx_word <= word;
                rx_flag <= flag;
                rx_count <= rx_count + 8'h01;
            end
        end
    end
endmodule

/* testbench.sv */
// self-checking bench for the converter output block
`timescale 1ns/10ps
module testbench;
    // design inputs
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic clk_en = 1'b1;
    logic pin = 1'b0;
    logic pin_n = 1'b1;
    logic [9:0] ain_pos = 10'h000;
    logic [9:0] ain_neg = 10'h000;
    logic div_sel = 1'b0;
    logic fmt_sel = 1'b0;
    // design outputs
    logic [7:0] word_t;
    logic [7:0] word_c;
    logic flag_t;
    logic flag_c;
    logic dck_t;
    logic dck_c;
    // receiver view
    logic [7:0] rx_word;
    logic rx_flag;
    logic [7:0] rx_count;
    // result counters
    int n_fail = 0;
    int cmp_count = 0;

    // 10 MHz system clock
    always #50 clock = ~clock;

    // block under test
    apo_top dut (
        .clock(clock), .reset_n(reset_n), .clk_en(clk_en),
        .sample_clk_true(pin), .sample_clk_comp(pin_n),
        .analog_in_pos(ain_pos), .analog_in_neg(ain_neg),
        .clock_divide_select(div_sel), .format_select(fmt_sel),
        .sample_word_true(word_t), .sample_word_comp(word_c),
        .range_flag_true(flag_t), .range_flag_comp(flag_c),
        .data_clk_out_true(dck_t), .data_clk_out_comp(dck_c)
    );

    // far-side receiver
    apo_rx_model rx (
        .clock(clock), .reset_n(reset_n), .word(word_t), .flag(flag_t), .dck(dck_t),
        .rx_word(rx_word), .rx_flag(rx_flag), .rx_count(rx_count)
    );

    // compare one value against its expectation
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // print counts and verdict, then stop
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // one sampling clock period of six system cycles; the receiver has latched by the end
    task automatic smp();
        @(negedge clock);
        pin = 1'b1;
        pin_n = 1'b0;
        repeat (3) @(negedge clock);
        pin = 1'b0;
        pin_n = 1'b1;
        repeat (2) @(negedge clock);
    endtask

    // complement pins always mirror the true pins
    task automatic chk_pairs();
        chk("word comp", word_c, ~word_t);
        chk("flag comp", {7'h00, flag_c}, {7'h00, ~flag_t});
        chk("dck comp", {7'h00, dck_c}, {7'h00, ~dck_t});
    endtask

    // output levels while reset is held
    task automatic t_reset();
        chk("rst word", word_t, 8'h00);
        chk("rst word comp", word_c, 8'hff);
        chk("rst flag", {7'h00, flag_t}, 8'h00);
        chk("rst dck", {7'h00, dck_t}, 8'h00);
        chk_pairs();
    endtask

    // divide enabled by default low select: half the sample edges update the output
    task automatic t_divide();
        logic [7:0] n0;
        n0 = rx_count;
        repeat (8) smp();
        chk("div count", rx_count - n0, 8'h04);
        chk_pairs();
    endtask

    // clock enable low freezes the whole path
    task automatic t_freeze();
        logic [7:0] n0;
        @(negedge clock);
        clk_en = 1'b0;
        n0 = rx_count;
        repeat (3) smp();
        chk("frozen count", rx_count - n0, 8'h00);
        @(negedge clock);
        clk_en = 1'b1;
    endtask

    // bypass mode: coding table, clamps, range flag, nine-tick latency, one word per edge
    task automatic t_coding();
        int d[6] = '{300, 256, 0, -256, -300, 100};
        logic [7:0] e[6] = '{8'hff, 8'hff, 8'h80, 8'h00, 8'h00, 8'hb2};
        logic [7:0] f[6] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
        logic [7:0] n0;
        @(negedge clock);
        div_sel = 1'b1;
        for (int i = 0; i < 6; i++) begin
            @(negedge clock);
            ain_pos = 10'(400 + d[i]);
            ain_neg = 10'h190;
            fmt_sel = 1'b1;
            n0 = rx_count;
            repeat (9) smp();
            if (i > 0) begin
                chk("old word", rx_word, e[i - 1]);
            end
            smp();
            chk("new word", rx_word, e[i]);
            chk("flag", {7'h00, rx_flag}, f[i]);
            chk("bypass count", rx_count - n0, 8'h0a);
            chk_pairs();
            @(negedge clock);
            fmt_sel = 1'b0;
            smp();
            chk("twos word", rx_word, e[i] ^ 8'h80);
            chk("twos flag", {7'h00, rx_flag}, f[i]);
        end
    endtask

    // watchdog: the tests need well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clock);
        n_fail++;
        end_sim();
    end

    // main sequence
    initial begin
        repeat (16) @(negedge clock);
        t_reset();
        reset_n = 1'b1;
        repeat (4) @(negedge clock);
        t_divide();
        t_freeze();
        t_coding();
        end_sim();
    end
endmodule
